//--- design/wrs_defs.svh
// Purpose: Offsets, field positions, reset values and timing bases for the supervisor
// Assumes: 20 MHz system clock; timers count a 10 us tick
// Notes: Definitions only
`ifndef WRS_DEFS_SVH
`define WRS_DEFS_SVH
`define WRS_CLK_NS 50
`define WRS_TICK_NS 10000
`define WRS_CNT_W 20
`define WRS_REG_RSTCFG 8'h0d
`define WRS_REG_SDRAIL 8'h0e
`define WRS_REG_WDCFG 8'h0f
`define WRS_REG_SWCMD 8'h16
`define WRS_REG_SWFEAT 8'h18
`define WRS_REG_FAULT 8'h19
`define WRS_RST_POL_BIT 1
`define WRS_AUX_GATE_BIT 2
`define WRS_FLOAT_BIT 3
`define WRS_WD_MODE_BIT 3
`define WRS_SW_SD_BIT 2
`define WRS_SW_SD_EN_BIT 4
`define WRS_RSHOLD_LSB 4
`define WRS_SEL_LSB 0
`define WRS_RSTCFG_INIT 8'h78
`define WRS_SDRAIL_INIT 8'h03
`define WRS_WDCFG_INIT 8'h06
`define WRS_SWCMD_INIT 8'h00
`define WRS_SWFEAT_INIT 8'h10
`define WRS_FAIL_LIMIT 2'h3
`define WRS_NIN 11
`define WRS_IN_SUPPLY 0
`define WRS_IN_IGN 1
`define WRS_IN_LOWUV 2
`define WRS_IN_AUXUV 3
`define WRS_IN_KICK 4
`define WRS_IN_FLOAT 5
`define WRS_IN_MR_N 6
`define WRS_IN_SCL 7
`define WRS_IN_SDA 8
`define WRS_IN_FUSE 9
`define WRS_IN_OVR 10
`define WRS_FS_SUPPLY 0
`define WRS_FS_IGN 1
`define WRS_FS_WD 2
`define WRS_FS_SW 3
`endif

//--- design/wrs_pkg.sv
// Purpose: Types of the supervisor
// Assumes: wrs_defs.svh holds the numbers
// Notes: Serial slave states are Gray coded along the usual path
package wrs_pkg;
   typedef enum logic [3:0] {
      I2C_IDLE = 4'h0,
      I2C_ADDR = 4'h1,
      I2C_AACK = 4'h3,
      I2C_PTR = 4'h2,
      I2C_PACK = 4'h6,
      I2C_WR = 4'h7,
      I2C_WACK = 4'h5,
      I2C_RD = 4'h4,
      I2C_RACK = 4'hc
   } wrs_i2c_t;
endpackage

//--- design/wrs_supervisor.sv
// Purpose: Watchdog, manual reset, reset and shutdown generators, warning and aux comparator outputs
// Assumes: Comparator results arrive as logic levels; registers reached over a two-wire serial slave
// Notes: Open-drain pins drive low while their enable is low
`timescale 1ns/1ns
`include "wrs_defs.svh"
module wrs_supervisor #(
   parameter logic [6:0] DEV_ADDR = 7'h2a,
   parameter int WD_US [8] = '{100000, 200000, 400000, 600000, 800000, 1000000, 1500000, 2000000},
   parameter int RS_HOLD_US [8] = '{100, 1000, 5000, 10000, 20000, 50000, 100000, 200000},
   parameter int SD_HOLD_US [8] = '{70, 1000, 5000, 10000, 20000, 50000, 100000, 200000},
   parameter int SD_DELAY_US = 100000,
   parameter int MR_DELAY_US = 100,
   parameter int WD_SD_US = 1000000
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic supply_monitor_in,
   input wire logic ignition_monitor_in,
   input wire logic low_rail_monitor_in,
   input wire logic aux_rail_monitor_in,
   input wire logic watchdog_kick_input,
   input wire logic kick_floating,
   input wire logic manual_reset_n,
   input wire logic fuse_blown,
   input wire logic otp_override,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic reset_out,
   output logic shutdown_out_n,
   output logic shutdown_warning_n,
   output logic aux_compare_out,
   output logic aux_compare_oe_n
);
   localparam int TICK_CYC = `WRS_TICK_NS / `WRS_CLK_NS;
   localparam int NIN = `WRS_NIN;
   localparam int CW = `WRS_CNT_W;
   localparam logic [NIN-1:0] PIN_IDLE = (NIN'(1) << `WRS_IN_MR_N) | (NIN'(1) << `WRS_IN_SCL)
                                         | (NIN'(1) << `WRS_IN_SDA);

   // Least time in microseconds to whole ticks, rounded up, never below one
   // Delays and holds run one tick past the limit: the free tick phase must never shorten them
   function automatic logic [CW-1:0] us2t(input int us);
      longint t;
      t = (longint'(us) * 64'sd1000 + longint'(`WRS_TICK_NS) - 64'sd1) / longint'(`WRS_TICK_NS);
      if (t < 64'sd1) begin
         t = 64'sd1;
      end
      return t[CW-1:0];
   endfunction

   typedef struct packed {
      logic [NIN-1:0] s1;
      logic [NIN-1:0] s2;
      logic [NIN-1:0] s3;
      logic [NIN-1:0] flt;
      logic [7:0] tick_cnt;
      logic tick;
      logic pwrup;
      logic kick_prev;
      logic [CW-1:0] wd_cnt;
      logic [1:0] fail_cnt;
      logic [CW-1:0] wdsd_cnt;
      logic [CW-1:0] dly_cnt;
      logic [CW-1:0] sdh_cnt;
      logic [CW-1:0] rsh_cnt;
      logic [CW-1:0] mr_cnt;
      logic [7:0] rstcfg;
      logic [7:0] sdrail;
      logic [7:0] wdcfg;
      logic [7:0] swcmd;
      logic [7:0] swfeat;
      logic [7:0] fstat;
      wrs_pkg::wrs_i2c_t ist;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic rw;
      logic sda_oe_n;
      logic reset_out;
      logic sd_n;
      logic warn_n;
      logic aux_oe_n;
   } wrs_state_t;

   wrs_state_t q;
   wrs_state_t n;
   logic [NIN-1:0] pins;
   logic kick_edge, wd_en, fire, fault, sw_sd, sd_req, sd_on, mr_req, rs_level, rs_on;
   logic scl_rise, scl_fall, i2c_start, i2c_stop, rd_clr;
   logic [CW-1:0] wd_lim, rsh_lim, sdh_lim;

   assign pins = {otp_override, fuse_blown, sda_in, scl_in, manual_reset_n, kick_floating,
                  watchdog_kick_input, aux_rail_monitor_in, low_rail_monitor_in,
                  ignition_monitor_in, supply_monitor_in};

   always_comb begin
      n = q;
      n.s1 = pins;
      n.s2 = q.s1;
      n.s3 = q.s2;
      // A pin change counts once the last two stages agree
      for (int i = 0; i < NIN; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            n.flt[i] = q.s3[i];
         end
      end
      n.tick = 1'b0;
      n.tick_cnt = q.tick_cnt + 8'h01;
      if (q.tick_cnt == 8'(TICK_CYC - 1)) begin
         n.tick_cnt = 8'h00;
         n.tick = 1'b1;
      end
      n.pwrup = 1'b0;

      wd_lim = us2t(WD_US[q.wdcfg[`WRS_SEL_LSB +: 3]]);
      rsh_lim = us2t(RS_HOLD_US[q.rstcfg[`WRS_RSHOLD_LSB +: 3]]);
      sdh_lim = us2t(SD_HOLD_US[q.sdrail[`WRS_SEL_LSB +: 3]]);

      // Manual reset delay
      mr_req = 1'b0;
      if (q.flt[`WRS_IN_MR_N]) begin
         n.mr_cnt = '0;
      end else if (q.mr_cnt > us2t(MR_DELAY_US)) begin
         mr_req = 1'b1;
      end else if (q.tick) begin
         n.mr_cnt = q.mr_cnt + 1'b1;
      end

      // Supply and ignition faults warn at once and shut down after the delay
      fault = q.flt[`WRS_IN_SUPPLY] | q.flt[`WRS_IN_IGN];
      if (!fault) begin
         n.dly_cnt = '0;
      end else if (q.tick && q.dly_cnt <= us2t(SD_DELAY_US)) begin
         n.dly_cnt = q.dly_cnt + 1'b1;
      end
      sw_sd = ~q.swfeat[`WRS_SW_SD_EN_BIT] & q.swcmd[`WRS_SW_SD_BIT];
      sd_req = q.pwrup | sw_sd | (q.wdsd_cnt != '0)
               | (fault && q.dly_cnt > us2t(SD_DELAY_US));
      if (sd_req) begin
         n.sdh_cnt = sdh_lim + 1'b1;
      end else if (q.tick && q.sdh_cnt != '0) begin
         n.sdh_cnt = q.sdh_cnt - 1'b1;
      end
      sd_on = sd_req | (q.sdh_cnt != '0);

      // Watchdog
      rs_level = mr_req
                 | q.pwrup | sd_on | q.flt[`WRS_IN_LOWUV]
                 | (q.flt[`WRS_IN_AUXUV] & ~q.rstcfg[`WRS_AUX_GATE_BIT])
                 | (q.flt[`WRS_IN_FLOAT] & ~q.rstcfg[`WRS_FLOAT_BIT]);
      wd_en = ~q.pwrup & ~rs_level & (q.rsh_cnt == '0);
      kick_edge = q.flt[`WRS_IN_KICK] != q.kick_prev;
      n.kick_prev = q.flt[`WRS_IN_KICK];
      fire = 1'b0;
      if (!wd_en) begin
         n.wd_cnt = '0;
      end else if (kick_edge) begin
         n.wd_cnt = '0;
         n.fail_cnt = 2'h0;
      end else if (q.tick) begin
         if (q.wd_cnt >= wd_lim) begin
            fire = 1'b1;
            n.wd_cnt = '0;
            if (q.wdcfg[`WRS_WD_MODE_BIT] && q.fail_cnt == `WRS_FAIL_LIMIT) begin
               n.fail_cnt = 2'h0;
               n.wdsd_cnt = us2t(WD_SD_US);
            end else if (q.fail_cnt != `WRS_FAIL_LIMIT) begin
               n.fail_cnt = q.fail_cnt + 2'h1;
            end
         end else begin
            n.wd_cnt = q.wd_cnt + 1'b1;
         end
      end
      if (q.tick && q.wdsd_cnt != '0) begin
         n.wdsd_cnt = q.wdsd_cnt - 1'b1;
      end

      // Reset generator: level causes stretch by the hold; a watchdog fire is a hold-long pulse
      if (rs_level || fire) begin
         n.rsh_cnt = rsh_lim + 1'b1;
      end else if (q.tick && q.rsh_cnt != '0) begin
         n.rsh_cnt = q.rsh_cnt - 1'b1;
      end
      rs_on = rs_level | (q.rsh_cnt != '0);
      n.reset_out = q.rstcfg[`WRS_RST_POL_BIT] ? rs_on : ~rs_on;
      n.sd_n = ~sd_on;
      n.warn_n = ~fault;
      n.aux_oe_n = ~q.flt[`WRS_IN_AUXUV];

      // Two-wire register slave
      scl_rise = q.flt[`WRS_IN_SCL] & ~n.flt[`WRS_IN_SCL] ? 1'b0 : ~q.flt[`WRS_IN_SCL] & n.flt[`WRS_IN_SCL];
      scl_fall = q.flt[`WRS_IN_SCL] & ~n.flt[`WRS_IN_SCL];
      i2c_start = q.flt[`WRS_IN_SCL] & n.flt[`WRS_IN_SCL] & q.flt[`WRS_IN_SDA] & ~n.flt[`WRS_IN_SDA];
      i2c_stop = q.flt[`WRS_IN_SCL] & n.flt[`WRS_IN_SCL] & ~q.flt[`WRS_IN_SDA] & n.flt[`WRS_IN_SDA];
      rd_clr = 1'b0;
      if (i2c_start) begin
         n.ist = wrs_pkg::I2C_ADDR;
         n.bitc = 4'h0;
         n.sda_oe_n = 1'b1;
      end else if (i2c_stop) begin
         n.ist = wrs_pkg::I2C_IDLE;
         n.sda_oe_n = 1'b1;
      end else if (scl_rise) begin
         if (q.ist == wrs_pkg::I2C_ADDR || q.ist == wrs_pkg::I2C_PTR || q.ist == wrs_pkg::I2C_WR) begin
            n.sh = {q.sh[6:0], q.flt[`WRS_IN_SDA]};
            n.bitc = q.bitc + 4'h1;
         end else if (q.ist == wrs_pkg::I2C_RACK) begin
            n.rw = ~q.flt[`WRS_IN_SDA];
         end
      end else if (scl_fall) begin
         unique case (q.ist)
            wrs_pkg::I2C_IDLE: begin
               n.sda_oe_n = 1'b1;
            end
            wrs_pkg::I2C_ADDR: begin
               if (q.bitc == 4'h8) begin
                  if (q.sh[7:1] == DEV_ADDR) begin
                     n.ist = wrs_pkg::I2C_AACK;
                     n.rw = q.sh[0];
                     n.sda_oe_n = 1'b0;
                  end else begin
                     n.ist = wrs_pkg::I2C_IDLE;
                  end
               end
            end
            wrs_pkg::I2C_PTR: begin
               if (q.bitc == 4'h8) begin
                  n.ptr = q.sh;
                  n.ist = wrs_pkg::I2C_PACK;
                  n.sda_oe_n = 1'b0;
               end
            end
            wrs_pkg::I2C_WR: begin
               if (q.bitc == 4'h8) begin
                  n.ist = wrs_pkg::I2C_WACK;
                  n.sda_oe_n = 1'b0;
                  unique case (q.ptr)
                     `WRS_REG_RSTCFG: begin
                        n.rstcfg = q.sh;
                        if (q.flt[`WRS_IN_FUSE] && !q.flt[`WRS_IN_OVR]) begin
                           n.rstcfg[`WRS_FLOAT_BIT] = q.rstcfg[`WRS_FLOAT_BIT];
                        end
                     end
                     `WRS_REG_SDRAIL: n.sdrail = q.sh;
                     `WRS_REG_WDCFG: n.wdcfg = q.sh;
                     `WRS_REG_SWCMD: n.swcmd = q.sh;
                     `WRS_REG_SWFEAT: n.swfeat = q.sh;
                     default: n.swcmd = q.swcmd;
                  endcase
               end
            end
            wrs_pkg::I2C_AACK, wrs_pkg::I2C_PACK, wrs_pkg::I2C_WACK, wrs_pkg::I2C_RACK: begin
               n.bitc = 4'h0;
               n.sda_oe_n = 1'b1;
               if (q.ist == wrs_pkg::I2C_PACK || q.ist == wrs_pkg::I2C_WACK) begin
                  n.ist = wrs_pkg::I2C_WR;
               end else if (q.ist == wrs_pkg::I2C_AACK && !q.rw) begin
                  n.ist = wrs_pkg::I2C_PTR;
               end else if (q.ist == wrs_pkg::I2C_RACK && !q.rw) begin
                  n.ist = wrs_pkg::I2C_IDLE;
               end else begin
                  n.ist = wrs_pkg::I2C_RD;
                  unique case (q.ptr)
                     `WRS_REG_RSTCFG: n.sh = q.rstcfg;
                     `WRS_REG_SDRAIL: n.sh = q.sdrail;
                     `WRS_REG_WDCFG: n.sh = q.wdcfg;
                     `WRS_REG_SWCMD: n.sh = q.swcmd;
                     `WRS_REG_SWFEAT: n.sh = q.swfeat;
                     `WRS_REG_FAULT: begin
                        n.sh = q.fstat;
                        rd_clr = 1'b1;
                     end
                     default: n.sh = 8'h00;
                  endcase
                  n.sda_oe_n = n.sh[7];
               end
            end
            wrs_pkg::I2C_RD: begin
               if (q.bitc == 4'h7) begin
                  n.ist = wrs_pkg::I2C_RACK;
                  n.sda_oe_n = 1'b1;
               end else begin
                  n.bitc = q.bitc + 4'h1;
                  n.sh = {q.sh[6:0], 1'b0};
                  n.sda_oe_n = q.sh[6];
               end
            end
         endcase
      end

      // Sticky fault causes, cleared by reading; a new cause in the same cycle survives
      n.fstat = rd_clr ? 8'h00 : q.fstat;
      n.fstat[`WRS_FS_SUPPLY] = n.fstat[`WRS_FS_SUPPLY] | q.flt[`WRS_IN_SUPPLY];
      n.fstat[`WRS_FS_IGN] = n.fstat[`WRS_FS_IGN] | q.flt[`WRS_IN_IGN];
      n.fstat[`WRS_FS_WD] = n.fstat[`WRS_FS_WD] | (q.wdsd_cnt != '0);
      n.fstat[`WRS_FS_SW] = n.fstat[`WRS_FS_SW] | sw_sd;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '0;
         // Sync stages start at the idle pin levels so no false edge or fault follows reset
         q.s1 <= PIN_IDLE;
         q.s2 <= PIN_IDLE;
         q.s3 <= PIN_IDLE;
         q.flt <= PIN_IDLE;
         q.pwrup <= 1'b1;
         q.rstcfg <= `WRS_RSTCFG_INIT;
         q.sdrail <= `WRS_SDRAIL_INIT;
         q.wdcfg <= `WRS_WDCFG_INIT;
         q.swcmd <= `WRS_SWCMD_INIT;
         q.swfeat <= `WRS_SWFEAT_INIT;
         q.ist <= wrs_pkg::I2C_IDLE;
         q.sda_oe_n <= 1'b1;
         q.reset_out <= 1'b0;
         q.sd_n <= 1'b0;
         q.warn_n <= 1'b1;
         q.aux_oe_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign sda_out = q.tick & 1'b0;
   assign sda_oe_n = q.sda_oe_n;
   assign reset_out = q.reset_out;
   assign shutdown_out_n = q.sd_n;
   assign shutdown_warning_n = q.warn_n;
   assign aux_compare_out = q.pwrup & 1'b0;
   assign aux_compare_oe_n = q.aux_oe_n;

   AST_WD_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
      (q.rsh_cnt != '0) |=> (q.wd_cnt == '0)) else $error("watchdog counter not cleared in reset");
   AST_WD_POWERUP: assert property (@(posedge sys_clk) disable iff (reset)
      q.pwrup |=> (q.wd_cnt == '0) ##1 (q.wd_cnt == '0)) else $error("watchdog ran during power-up");
   AST_MR_PRIO: assert property (@(posedge sys_clk) disable iff (reset)
      mr_req |=> (q.reset_out == q.rstcfg[`WRS_RST_POL_BIT])) else $error("manual reset not obeyed");
   AST_SW_SD: assert property (@(posedge sys_clk) disable iff (reset)
      sw_sd |=> !shutdown_out_n) else $error("software shutdown not driven");
   AST_SD_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(sd_req) |=> !shutdown_out_n [*2]) else $error("shutdown released before hold");
   AST_WARN_FIRST: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(fault) |=> !shutdown_warning_n ##1 !shutdown_warning_n) else $error("warning late");
   AST_ADV_SD: assert property (@(posedge sys_clk) disable iff (reset)
      (fire && q.wdcfg[`WRS_WD_MODE_BIT] && q.fail_cnt == `WRS_FAIL_LIMIT) |=> ##1 !shutdown_out_n)
      else $error("advanced watchdog shutdown missing");
   AST_FLOAT_RST: assert property (@(posedge sys_clk) disable iff (reset)
      (q.flt[`WRS_IN_FLOAT] && !q.rstcfg[`WRS_FLOAT_BIT]) |=> (q.rsh_cnt == rsh_lim + 1'b1))
      else $error("floating kick reset missing");
   AST_FIRE_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
      fire |=> (q.wd_cnt == '0) ##1 (q.reset_out == q.rstcfg[`WRS_RST_POL_BIT]))
      else $error("watchdog fire gave no reset");
endmodule

//--- verif/wrs_proc_model.sv
// Purpose: System processor model: kicks the watchdog, masters the two-wire bus
// Assumes: Bus phases of 10 clocks; SDA has a pull-up
// Notes: acc is called from tb_top
`timescale 1ns/1ns
module wrs_proc_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2a
) (
   input wire logic sys_clk,
   input wire logic kick_en,
   input wire logic [9:0] kick_half,
   input wire logic sda_oe_n,
   input wire logic sda_out,
   output logic watchdog_kick_input,
   output logic scl,
   output logic sda_line,
   output logic [7:0] nack_cnt
);
   logic sda_low;
   logic [9:0] kick_cnt_r;
   // Pull-up: whoever pulls low wins
   assign sda_line = !(sda_low || (!sda_oe_n && !sda_out));
   initial begin
      watchdog_kick_input = 1'b0;
      scl = 1'b1;
      sda_low = 1'b0;
      nack_cnt = 8'h00;
      kick_cnt_r = 10'h000;
   end
   always @(posedge sys_clk) begin
      if (kick_en) begin
         kick_cnt_r <= (kick_cnt_r >= kick_half) ? 10'h000 : kick_cnt_r + 10'h001;
         if (kick_cnt_r >= kick_half) begin
            watchdog_kick_input <= !watchdog_kick_input;
         end
      end
   end
   task automatic ph(input logic c, input logic d);
      scl = c;
      sda_low = !d;
      repeat (10) @(posedge sys_clk);
      #5;
   endtask
   task automatic start();
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
      ph(1'b0, 1'b0);
   endtask
   // Eight bits MSB first, then the acknowledge bit
   task automatic xfer(input logic [7:0] tx, input logic mack, input logic chk, output logic [7:0] rx);
      logic d;
      for (int i = 8; i >= 0; i--) begin
         d = (i == 0) ? !mack : tx[i - 1];
         ph(1'b0, d);
         ph(1'b1, d);
         if (i > 0) begin
            rx[i - 1] = sda_line;
         end else if (chk && sda_line) begin
            nack_cnt++;
         end
         ph(1'b0, d);
      end
   endtask
   task automatic acc(input logic rd, input logic [7:0] ptr, input logic [7:0] wv, output logic [7:0] rv);
      logic [7:0] d;
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b0, 1'b1, d);
      xfer(ptr, 1'b0, 1'b1, d);
      if (rd) begin
         start();
         xfer({DEV_ADDR, 1'b1}, 1'b0, 1'b1, d);
         // Last byte left unacknowledged to end the read
         xfer(8'hff, 1'b0, 1'b0, rv);
      end else begin
         xfer(wv, 1'b0, 1'b1, d);
      end
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
   endtask
endmodule

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the supervisor
// Assumes: Shortened timings, one tick is 200 clocks
// Notes: Each note holds an expected output and a cycle budget
`timescale 1ns/1ns
module tb_top;
   typedef struct {int idx; logic [7:0] val; int hold; int lim;} wrs_note_t;
   localparam logic [7:0] L = 8'h00;
   localparam logic [7:0] H = 8'h01;
   logic sys_clk, reset, supply_monitor_in, ignition_monitor_in, low_rail_monitor_in;
   logic aux_rail_monitor_in, watchdog_kick_input, kick_floating, manual_reset_n;
   logic fuse_blown, otp_override, scl, sda_line, sda_out, sda_oe_n, reset_out;
   logic shutdown_out_n, shutdown_warning_n, aux_compare_oe_n, kick_en;
   logic [9:0] kick_half;
   logic [7:0] nack_cnt, rd_byte, junk;
   wrs_note_t notes[$];
   int err_count = 0;
   int n_tests = 0;
   string nm [6] = '{"reset_out", "shutdown_out_n", "shutdown_warning_n", "aux_compare_oe_n", "read_data", "nacks"};
   wrs_supervisor #(.WD_US('{8{100}}), .RS_HOLD_US('{8{20}}), .SD_HOLD_US('{8{20}}), .SD_DELAY_US(20),
      .MR_DELAY_US(10), .WD_SD_US(200)) DUT (.sys_clk, .reset, .supply_monitor_in, .ignition_monitor_in,
      .low_rail_monitor_in, .aux_rail_monitor_in, .watchdog_kick_input, .kick_floating, .manual_reset_n,
      .fuse_blown, .otp_override, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n, .reset_out,
      .shutdown_out_n, .shutdown_warning_n, .aux_compare_out(), .aux_compare_oe_n);
   wrs_proc_model cpu (.sys_clk, .kick_en, .kick_half, .sda_oe_n, .sda_out, .watchdog_kick_input,
      .scl, .sda_line, .nack_cnt);
   function automatic logic [7:0] obs(int i);
      case (i)
         0: return {7'h00, reset_out};
         1: return {7'h00, shutdown_out_n};
         2: return {7'h00, shutdown_warning_n};
         3: return {7'h00, aux_compare_oe_n};
         4: return rd_byte;
         default: return nack_cnt;
      endcase
   endfunction
   task automatic chk_pin(string n, logic e, logic s);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %b seen %b", n, e, s);
      end
   endtask
   task automatic chk_byte(string n, logic [7:0] e, logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hold notes must stay true for lim cycles, others become true within lim
   task automatic ex(input int idx, input logic [7:0] val, input int hold, input int lim);
      notes.push_back('{idx, val, hold, lim});
      for (int k = 0; k < 20000 && notes.size() > 0; k++) begin
         @(posedge sys_clk);
      end
      if (notes.size() > 0) begin
         err_count++;
         tally_and_finish();
      end
      #5;
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      cpu.acc(1'b0, p, v, junk);
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      cpu.acc(1'b1, p, 8'h00, rd_byte);
      ex(4, e, 0, 0);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      wrs_note_t n;
      logic [7:0] s;
      forever begin
         @(negedge sys_clk);
         if (notes.size() > 0) begin
            n = notes[0];
            for (int i = 0; i < n.lim && ((obs(n.idx) === n.val) == (n.hold != 0)); i++) begin
               @(negedge sys_clk);
            end
            s = obs(n.idx);
            if (n.idx < 4) begin
               chk_pin(nm[n.idx], n.val[0], s[0]);
            end else begin
               chk_byte(nm[n.idx], n.val, s);
            end
            void'(notes.pop_front());
         end
      end
   end
   initial begin
      {reset, kick_en, manual_reset_n} = 3'b101;
      {supply_monitor_in, ignition_monitor_in, low_rail_monitor_in, aux_rail_monitor_in} = 4'h0;
      {kick_floating, fuse_blown, otp_override} = 3'b000;
      junk = 8'h00;
      rd_byte = 8'h00;
      void'($urandom(32'h9a8e));
      kick_half = 10'(200 + $urandom % 400);
      repeat (4) @(posedge sys_clk);
      #5;
      reset = 1'b0;
      ex(1, L, 1, 300);
      ex(1, H, 0, 600);
      ex(0, L, 0, 0);
      ex(0, H, 0, 700);
      for (int i = 0; i < 6; i++) begin
         if (i == 2) begin
            kick_en = 1'b1;
            ex(0, H, 1, 5000);
            wr(8'h0f, 8'h0e);
            kick_en = 1'b0;
         end
         ex(0, H, 1, 1200);
         if (i == 5) begin
            ex(1, L, 0, 1500);
            ex(0, L, 0, 0);
            ex(1, L, 1, 3500);
            ex(1, H, 0, 1200);
         end else begin
            ex(0, L, 0, 1500);
            ex(1, H, 0, 0);
            ex(0, L, 1, 300);
         end
         ex(0, H, 0, 1000);
      end
      kick_en = 1'b1;
      rd(8'h19, 8'h04);
      manual_reset_n = 1'b0;
      ex(0, L, 0, 450);
      ex(0, L, 1, 1000);
      manual_reset_n = 1'b1;
      ex(0, L, 1, 300);
      ex(0, H, 0, 400);
      wr(8'h16, 8'h04);
      ex(1, H, 1, 600);
      wr(8'h18, 8'h00);
      ex(1, L, 0, 300);
      ex(0, L, 0, 300);
      wr(8'h16, 8'h00);
      ex(1, L, 1, 300);
      ex(1, H, 0, 500);
      ex(0, H, 0, 900);
      rd(8'h19, 8'h08);
      supply_monitor_in = 1'b1;
      ex(2, L, 0, 30);
      ex(1, H, 0, 0);
      ex(1, L, 0, 700);
      supply_monitor_in = 1'b0;
      ex(2, H, 0, 30);
      ex(1, H, 0, 900);
      ex(0, H, 0, 900);
      rd(8'h19, 8'h01);
      rd(8'h20, 8'h00);
      for (int j = 0; j < 2; j++) begin
         if (j == 1) begin
            wr(8'h0d, 8'h7c);
         end
         aux_rail_monitor_in = 1'b1;
         ex(3, L, 0, 30);
         ex(0, (j == 0) ? L : H, j, (j == 0) ? 30 : 300);
         aux_rail_monitor_in = 1'b0;
         ex(3, H, 0, 30);
         ex(0, H, 0, 700);
      end
      wr(8'h0d, 8'h7a);
      ex(0, L, 0, 50);
      low_rail_monitor_in = 1'b1;
      ex(0, H, 0, 30);
      low_rail_monitor_in = 1'b0;
      ex(0, H, 1, 300);
      ex(0, L, 0, 400);
      fuse_blown = 1'b1;
      wr(8'h0d, 8'h72);
      rd(8'h0d, 8'h7a);
      kick_floating = 1'b1;
      ex(0, L, 1, 300);
      otp_override = 1'b1;
      wr(8'h0d, 8'h72);
      ex(0, H, 0, 300);
      kick_floating = 1'b0;
      ex(0, L, 0, 900);
      ex(5, L, 0, 0);
      tally_and_finish();
   end
endmodule
